// file: hdl/alu_ops_pkg.sv
/*
 * Shared constants, types and helpers for the accumulator datapath.
 * Assumes an Avalon-MM master with 32-bit data and byte addresses.
 */
`default_nettype none
package alu_ops_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam logic [9:0] ACCUM_OFS = 10'h000;
	localparam logic [9:0] STATUS_OFS = 10'h004;
	localparam logic [9:0] POINTER0_OFS = 10'h008;
	localparam logic [9:0] POINTER1_OFS = 10'h00C;
	localparam logic [9:0] COMMAND_OFS = 10'h010;
	// data memory window 0x200..0x3FC, one register per word
	localparam int MEM_SEL_BIT = 9;
	localparam int MEM_DEPTH_DEF = 128;
	localparam int MEM_AW = 7;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] ACCUM_RST = 8'h00;
	localparam logic [2:0] FLAGS_RST = 3'h0;
	localparam logic [15:0] POINTER_RST = 16'h0000;
	localparam logic [23:0] COMMAND_RST = 24'h000000;
	localparam logic [31:0] READDATA_RST = 32'h00000000;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_PTR_ADD = 4'h1,
		OP_AND_IMM = 4'h2,
		OP_ADD_IMM = 4'h3,
		OP_AND_REG = 4'h4,
		OP_ADD_REG = 4'h5,
		OP_SHIFT = 4'h6,
		OP_ADD_CARRY = 4'h7
	} op_t;

	typedef struct packed {
		logic [7:0] k;
		logic spare1;
		logic [6:0] f;
		logic [1:0] spare0;
		logic n;
		logic d;
		op_t op;
	} command_t;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} flags_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_WAIT = 3'b010,
		BUS_ANSWER = 3'b100
	} bus_state_t;

	typedef enum logic [2:0] {
		EX_IDLE = 3'b001,
		EX_FETCH = 3'b010,
		EX_EXEC = 3'b100
	} exec_state_t;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// returns {carry, nibble carry, sum}
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [4:0] hi;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		return {hi[4], lo[4], hi[3:0], lo[3:0]};
	endfunction

	function automatic logic [15:0] sext6(input logic [7:0] k);
		return {{10{k[5]}}, k[5:0]};
	endfunction

	function automatic logic is_reg_op(input op_t op);
		return op == OP_AND_REG || op == OP_ADD_REG || op == OP_SHIFT || op == OP_ADD_CARRY;
	endfunction

endpackage
`default_nettype wire

// file: hdl/data_regfile.sv
/*
 * Data-memory register file, one address shared by the write and the read.
 * Read data come out of a register one clock after the address.
 */
`default_nettype none
module data_regfile #(
	parameter int DEPTH = 128,
	parameter int AW = 7,
	parameter int W = 8
) (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] rdata_o
);

	logic [W-1:0] mem [DEPTH];

	// read returns the old word on a same-cycle write
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end

endmodule
`default_nettype wire

// file: hdl/add_and_shift_alu_ops.sv
/*
 * Accumulator datapath: pointer add, literal and register AND/ADD,
 * add with carry and arithmetic right shift, with carry/nibble/zero flags.
 * Assumes an Avalon-MM master on mclk_i that holds each request until
 * it samples waitrequest_o low.
 */
// Notes on behaviour
// RULE1: pointer add sign-extends six-bit literal onto chosen pointer, flags untouched.
// RULE2: pointer result stays sixteen bits, wrapping modulo 65536.
// RULE3: literal AND writes accumulator and changes only the zero flag.
// RULE4: literal add writes accumulator and updates carry, nibble and zero flags.
// RULE5: destination bit 0 selects accumulator, 1 writes back the register.
// RULE6: register AND goes to chosen destination, only zero flag changes.
// RULE7: register add goes to chosen destination, updates carry, nibble, zero.
// RULE8: shift right keeps bit seven, bit zero into carry, updates carry, zero.
// RULE9: add with carry sums accumulator, register and carry, updates three flags.
// RULE10: zero flag tracks all-zero result; nibble flag is carry out of bit three.
// RULE11: carry flag on adds is carry out of bit seven.
`default_nettype none
module add_and_shift_alu_ops
	import alu_ops_pkg::*;
#(
	parameter int MEM_DEPTH = MEM_DEPTH_DEF
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [DATA_W-1:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [DATA_W-1:0] readdata_o,
	output logic waitrequest_o
);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	bus_state_t bus_state;
	exec_state_t exec_state;
	command_t cmd;
	flags_t flags;
	flags_t next_flags;
	logic [7:0] accum;
	logic [7:0] next_result;
	logic [1:0][15:0] pointer;
	logic writes_accum;
	logic bus_ack;
	logic wr_ack;
	logic [31:0] read_word;
	logic mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [7:0] mem_wdata;
	logic [7:0] mem_q;

	assign bus_ack = (read_i || write_i) && bus_state == BUS_ANSWER;
	assign wr_ack = bus_ack && write_i;

	// ---------------------------------------------------------------
	// data memory
	// ---------------------------------------------------------------
	always_comb begin
		if (exec_state != EX_IDLE) begin
			mem_addr = cmd.f;
			mem_we = exec_state == EX_EXEC && is_reg_op(cmd.op) && cmd.d; // RULE5
			mem_wdata = next_result;
		end else begin
			mem_addr = address_i[8:2];
			mem_we = wr_ack && address_i[MEM_SEL_BIT] && byteenable_i[0];
			mem_wdata = writedata_i[7:0];
		end
	end

	data_regfile #(
		.DEPTH(MEM_DEPTH),
		.AW(MEM_AW),
		.W(8)
	) i_data_regfile (
		.mclk_i(mclk_i),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdata),
		.rdata_o(mem_q)
	);

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	always_comb begin
		read_word = 32'h00000000;
		if (address_i[MEM_SEL_BIT]) begin
			read_word = {24'h000000, mem_q};
		end else begin
			case (address_i)
				ACCUM_OFS: read_word = {24'h000000, accum};
				STATUS_OFS: read_word = {29'h00000000, flags};
				POINTER0_OFS: read_word = {16'h0000, pointer[0]};
				POINTER1_OFS: read_word = {16'h0000, pointer[1]};
				COMMAND_OFS: read_word = {8'h00, cmd};
				default: read_word = 32'h00000000;
			endcase
		end
	end

	// requests wait while the engine owns the memory port
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			bus_state <= BUS_IDLE;
			waitrequest_o <= 1'b1;
			readdata_o <= READDATA_RST;
		end else begin
			case (bus_state)
				BUS_IDLE: begin
					if ((read_i || write_i) && exec_state == EX_IDLE) begin
						bus_state <= BUS_WAIT;
					end
				end
				BUS_WAIT: begin
					bus_state <= BUS_ANSWER;
					waitrequest_o <= 1'b0;
					readdata_o <= read_word;
				end
				BUS_ANSWER: begin
					bus_state <= BUS_IDLE;
					waitrequest_o <= 1'b1;
				end
				default: begin
					bus_state <= BUS_IDLE;
					waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// execution sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			exec_state <= EX_IDLE;
			cmd <= command_t'(COMMAND_RST);
		end else begin
			case (exec_state)
				EX_IDLE: begin
					if (wr_ack && address_i == COMMAND_OFS && byteenable_i[0]) begin
						cmd <= command_t'(writedata_i[23:0]);
						exec_state <= EX_FETCH;
					end
				end
				EX_FETCH: exec_state <= EX_EXEC;
				EX_EXEC: exec_state <= EX_IDLE;
				default: exec_state <= EX_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// arithmetic
	// ---------------------------------------------------------------
	always_comb begin
		logic z_upd;
		z_upd = 1'b0;
		next_result = accum;
		next_flags = flags;
		writes_accum = 1'b0;
		case (cmd.op)
			OP_AND_IMM: begin
				next_result = accum & cmd.k; // RULE3
				z_upd = 1'b1;
				writes_accum = 1'b1;
			end
			OP_ADD_IMM: begin
				{next_flags.c, next_flags.dc, next_result} = add8(accum, cmd.k, 1'b0); // RULE4
				z_upd = 1'b1;
				writes_accum = 1'b1;
			end
			OP_AND_REG: begin
				next_result = accum & mem_q; // RULE6
				z_upd = 1'b1;
				writes_accum = !cmd.d;
			end
			OP_ADD_REG: begin
				{next_flags.c, next_flags.dc, next_result} = add8(accum, mem_q, 1'b0); // RULE7
				z_upd = 1'b1;
				writes_accum = !cmd.d;
			end
			OP_SHIFT: begin
				next_result = {mem_q[7], mem_q[7:1]}; // RULE8
				next_flags.c = mem_q[0]; // RULE8
				z_upd = 1'b1;
				writes_accum = !cmd.d;
			end
			OP_ADD_CARRY: begin
				{next_flags.c, next_flags.dc, next_result} = add8(accum, mem_q, flags.c); // RULE9
				z_upd = 1'b1;
				writes_accum = !cmd.d; // RULE5
			end
			default: begin
				z_upd = 1'b0;
			end
		endcase
		if (z_upd) begin
			next_flags.z = next_result == 8'h00; // RULE10
		end
	end

	// ---------------------------------------------------------------
	// accumulator, flags, pointers
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			accum <= ACCUM_RST;
		end else if (exec_state == EX_EXEC && writes_accum) begin
			accum <= next_result; // RULE5
		end else if (wr_ack && address_i == ACCUM_OFS && byteenable_i[0]) begin
			accum <= writedata_i[7:0];
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			flags <= flags_t'(FLAGS_RST);
		end else if (exec_state == EX_EXEC) begin
			flags <= next_flags; // RULE11
		end else if (wr_ack && address_i == STATUS_OFS && byteenable_i[0]) begin
			flags <= flags_t'(writedata_i[2:0]);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			pointer <= {POINTER_RST, POINTER_RST};
		end else if (exec_state == EX_EXEC && cmd.op == OP_PTR_ADD) begin
			pointer[cmd.n] <= pointer[cmd.n] + sext6(cmd.k); // RULE1 RULE2
		end else if (wr_ack && (address_i == POINTER0_OFS || address_i == POINTER1_OFS)) begin
			if (byteenable_i[0]) begin
				pointer[address_i[2]][7:0] <= writedata_i[7:0];
			end
			if (byteenable_i[1]) begin
				pointer[address_i[2]][15:8] <= writedata_i[15:8];
			end
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);

	sequence exec_of(op_t o);
		exec_state == EX_EXEC && cmd.op == o;
	endsequence

	sequence cmd_launch;
		exec_state == EX_IDLE && wr_ack && address_i == COMMAND_OFS && byteenable_i[0];
	endsequence

	sequence engine_run;
		exec_state == EX_FETCH ##1 exec_state == EX_EXEC ##1 exec_state == EX_IDLE;
	endsequence

	launch_order_a: assert property (cmd_launch |=> engine_run)
		else $error("command did not run fetch then execute");

	bus_answer_a: assert property ((read_i || write_i) && bus_state == BUS_IDLE
		&& exec_state == EX_IDLE |=> waitrequest_o ##1 !waitrequest_o ##1 waitrequest_o)
		else $error("bus answer timing wrong");

	pointer_add_a: assert property (exec_of(OP_PTR_ADD) |=> // RULE1 RULE2
		pointer[$past(cmd.n)] == 16'($past(pointer[cmd.n]) + sext6($past(cmd.k))))
		else $error("pointer add result wrong");

	pointer_flags_a: assert property (exec_of(OP_PTR_ADD) |=> $stable(flags)) // RULE1
		else $error("pointer add changed flags");

	and_imm_a: assert property (exec_of(OP_AND_IMM) |=> accum == ($past(accum) & $past(cmd.k)) // RULE3
		&& flags.c == $past(flags.c) && flags.dc == $past(flags.dc))
		else $error("literal AND wrong");

	add_imm_a: assert property (exec_of(OP_ADD_IMM) |=> // RULE4
		{flags.c, accum} == {1'b0, $past(accum)} + {1'b0, $past(cmd.k)})
		else $error("literal add wrong");

	dest_mem_a: assert property (exec_state == EX_EXEC && is_reg_op(cmd.op) && cmd.d // RULE5
		|-> mem_we && mem_addr == cmd.f ##1 $stable(accum))
		else $error("register destination not honoured");

	dest_accum_a: assert property (exec_state == EX_EXEC && is_reg_op(cmd.op) && !cmd.d // RULE5
		|-> !mem_we ##1 accum == $past(next_result))
		else $error("accumulator destination not honoured");

	and_reg_a: assert property (exec_of(OP_AND_REG) |=> // RULE6
		$past(next_result) == ($past(accum) & $past(mem_q)) && flags.c == $past(flags.c))
		else $error("register AND wrong");

	add_reg_a: assert property (exec_of(OP_ADD_REG) |=> // RULE7
		{flags.c, $past(next_result)} == {1'b0, $past(accum)} + {1'b0, $past(mem_q)})
		else $error("register add wrong");

	shift_a: assert property (exec_of(OP_SHIFT) |=> flags.c == $past(mem_q[0]) // RULE8
		&& $past(next_result) == {$past(mem_q[7]), $past(mem_q[7:1])}
		&& flags.dc == $past(flags.dc))
		else $error("arithmetic shift wrong");

	carry_add_a: assert property (exec_of(OP_ADD_CARRY) |=> {flags.c, $past(next_result)} // RULE9
		== {1'b0, $past(accum)} + {1'b0, $past(mem_q)} + {8'h00, $past(flags.c)})
		else $error("add with carry wrong");

	zero_flag_a: assert property (exec_state == EX_EXEC && cmd.op >= OP_AND_IMM // RULE10
		&& cmd.op <= OP_ADD_CARRY |=> flags.z == ($past(next_result) == 8'h00))
		else $error("zero flag wrong");

	nibble_a: assert property (exec_of(OP_ADD_REG) |=> // RULE10
		flags.dc == (5'({1'b0, $past(accum[3:0])}) + 5'({1'b0, $past(mem_q[3:0])}) > 5'h0F))
		else $error("nibble flag wrong");

endmodule
`default_nettype wire

// file: dv/tb_add_and_shift_alu_ops.sv
/*
 * Self-checking bench for the accumulator datapath: register access,
 * pointer add and every datapath command, against a bench-side model.
 * Holds each bus request until it samples waitrequest_o low, as the design's note asks.
 */
`default_nettype none
module tb_add_and_shift_alu_ops
	import alu_ops_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i;
	logic reset_n_i;
	logic [ADDR_W-1:0] address_i;
	logic read_i;
	logic write_i;
	logic [DATA_W-1:0] writedata_i;
	logic [3:0] byteenable_i;
	logic [DATA_W-1:0] readdata_o;
	logic waitrequest_o;
	int n_errors = 0;
	int n_tests = 0;
	int seed = 49;
	logic [31:0] exp_q[$];
	logic [7:0] m_acc;
	logic m_c;
	logic m_dc;
	logic m_z;
	logic [15:0] m_ptr[2];
	logic [7:0] m_mem[MEM_DEPTH_DEF];
	logic [23:0] m_cmd;

	add_and_shift_alu_ops #(.MEM_DEPTH(MEM_DEPTH_DEF)) i_add_and_shift_alu_ops (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.address_i(address_i),
		.read_i(read_i),
		.write_i(write_i),
		.writedata_i(writedata_i),
		.byteenable_i(byteenable_i),
		.readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o)
	);

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// ---------------------------------------------------------------
	// reporting
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// ---------------------------------------------------------------
	// bus master
	// ---------------------------------------------------------------
	task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int i;
		address_i <= a;
		writedata_i <= d;
		byteenable_i <= be;
		write_i <= wr;
		read_i <= !wr;
		i = 0;
		do begin
			@(posedge mclk_i);
			i++;
		end while (waitrequest_o !== 1'b0 && i < 40);
		if (waitrequest_o !== 1'b0) begin
			n_errors++;
			$display("mismatch waitrequest expected 0 seen %b", waitrequest_o);
			stop_test();
		end else begin
			read_i <= 1'b0;
			write_i <= 1'b0;
			@(posedge mclk_i);
		end
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h00000000, 4'hF);
	endtask

	// answers are matched against the oldest note
	always @(posedge mclk_i) begin
		if (read_i === 1'b1 && waitrequest_o === 1'b0) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("mismatch answer count expected 0 seen 1");
			end else begin
				check($sformatf("read %h", address_i), readdata_o, exp_q.pop_front());
			end
		end
	end

	// ---------------------------------------------------------------
	// model and stimulus
	// ---------------------------------------------------------------
	task automatic set_regs(input logic [31:0] a, input logic [31:0] p);
		bus(1'b1, ACCUM_OFS, a, 4'hF);
		bus(1'b1, STATUS_OFS, a >> 8, 4'hF);
		bus(1'b1, POINTER0_OFS, p, 4'hF);
		bus(1'b1, POINTER1_OFS, p >> 16, 4'hF);
		m_acc = a[7:0];
		{m_z, m_dc, m_c} = a[10:8];
		m_ptr[0] = p[15:0];
		m_ptr[1] = p[31:16];
	endtask

	task automatic cmd(input op_t op, input logic d, input logic n, input logic [6:0] f,
		input logic [7:0] k);
		command_t c;
		logic [7:0] b;
		logic [7:0] r;
		logic [8:0] s;
		logic cin;
		c = '0;
		c.op = op;
		c.d = d;
		c.n = n;
		c.f = f;
		c.k = k;
		bus(1'b1, COMMAND_OFS, {8'h00, c}, 4'hF);
		m_cmd = c;
		b = (op == OP_AND_IMM || op == OP_ADD_IMM) ? k : m_mem[f];
		cin = (op == OP_ADD_CARRY) && m_c;
		r = m_acc & b;
		s = {1'b0, m_acc} + {1'b0, b} + {8'h00, cin};
		case (op)
			OP_PTR_ADD: m_ptr[n] = m_ptr[n] + {{10{k[5]}}, k[5:0]};
			OP_AND_IMM, OP_AND_REG: m_z = (r == 8'h00);
			OP_ADD_IMM, OP_ADD_REG, OP_ADD_CARRY: begin
				m_dc = ({1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}) > 5'h0F;
				m_c = s[8];
				r = s[7:0];
				m_z = (r == 8'h00);
			end
			OP_SHIFT: begin
				m_c = b[0];
				r = {b[7], b[7:1]};
				m_z = (r == 8'h00);
			end
			default: ;
		endcase
		if (op == OP_AND_IMM || op == OP_ADD_IMM) begin
			m_acc = r;
		end else if (op >= OP_AND_REG && op <= OP_ADD_CARRY) begin
			if (d) begin
				m_mem[f] = r;
			end else begin
				m_acc = r;
			end
		end
	endtask

	task automatic check_state(input logic [6:0] f);
		rd(ACCUM_OFS, {24'h000000, m_acc});
		rd(STATUS_OFS, {29'h00000000, m_z, m_dc, m_c});
		rd(POINTER0_OFS, {16'h0000, m_ptr[0]});
		rd(POINTER1_OFS, {16'h0000, m_ptr[1]});
		rd(COMMAND_OFS, {8'h00, m_cmd});
		rd({1'b1, f, 2'b00}, {24'h000000, m_mem[f]});
	endtask

	initial begin
		int i;
		logic [31:0] v;
		logic [31:0] w;
		reset_n_i = 1'b0;
		read_i = 1'b0;
		write_i = 1'b0;
		address_i = '0;
		writedata_i = '0;
		byteenable_i = 4'hF;
		m_acc = ACCUM_RST;
		{m_z, m_dc, m_c} = FLAGS_RST;
		m_ptr[0] = POINTER_RST;
		m_ptr[1] = POINTER_RST;
		m_cmd = COMMAND_RST;
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		@(posedge mclk_i);
		for (i = 0; i < MEM_DEPTH_DEF; i++) begin
			v = $random(seed);
			bus(1'b1, {1'b1, i[6:0], 2'b00}, v, 4'hF);
			m_mem[i] = v[7:0];
		end
		check_state(7'h00);
		// unmapped place and a write with lane 0 off
		rd(10'h014, 32'h00000000);
		bus(1'b1, 10'h014, 32'hFFFFFFFF, 4'hF);
		bus(1'b1, ACCUM_OFS, 32'h000000A5, 4'hE);
		check_state(7'h01);
		// pointer wrap at both ends, flags set beforehand
		set_regs(32'h0000073C, 32'h0010FFF0);
		cmd(OP_PTR_ADD, 1'b0, 1'b0, 7'h00, 8'h1F);
		cmd(OP_PTR_ADD, 1'b1, 1'b1, 7'h00, 8'hE0);
		check_state(7'h00);
		// carry, nibble and zero all from one add
		set_regs(32'h000000FF, 32'h00000000);
		cmd(OP_ADD_IMM, 1'b0, 1'b0, 7'h02, 8'h01);
		check_state(7'h02);
		// every command but OP_NONE with both destinations
		for (i = 2; i < 16; i++) begin
			v = $random(seed);
			w = $random(seed);
			set_regs(v, w);
			cmd(op_t'(i[4:1]), i[0], v[12], w[6:0], v[23:16]);
			check_state(w[6:0]);
		end
		for (i = 0; i < 150; i++) begin
			v = $random(seed);
			w = $random(seed);
			set_regs(v, w);
			v = $random(seed);
			cmd(op_t'(v[3:0]), v[4], v[5], v[14:8], v[23:16]);
			check_state(v[14:8]);
		end
		if (exp_q.size() != 0) begin
			n_errors++;
			$display("mismatch pending reads expected 0 seen %0d", exp_q.size());
		end
		stop_test();
	end
endmodule
`default_nettype wire
